// file: src/atx_regs.svh
`ifndef ATX_REGS_SVH
`define ATX_REGS_SVH

// register byte offsets
`define ATX_OFF_ACC 12'h000
`define ATX_OFF_FILE_PTR 12'h004
`define ATX_OFF_DATA_PTR 12'h008
`define ATX_OFF_CARRY 12'h00c
`define ATX_OFF_INSTR 12'h010
`define ATX_OFF_STATUS 12'h014
`define ATX_OFF_INT_CTRL_ONE 12'h018
`define ATX_OFF_WAKE_CTRL_ZERO 12'h01c
`define ATX_OFF_WAKE_CTRL_ONE 12'h020
`define ATX_OFF_WAKE_CTRL_TWO 12'h024
`define ATX_OFF_CLOCK_CTRL 12'h028
`define ATX_OFF_PULLUP_CTRL_ZERO 12'h02c
`define ATX_OFF_PULLUP_CTRL_ONE 12'h030
`define ATX_OFF_RAM_BASE 12'h100

// field positions
`define ATX_STATUS_HIT_BIT 0
`define ATX_STATUS_SKIP_BIT 1
`define ATX_STATUS_COUNT_LSB 8

// reset values
`define ATX_RST_NIBBLE 4'h0
`define ATX_RST_OPCODE 10'h000

// 10-bit instruction codes
`define ATX_OPC_INT_CTRL_ONE 10'h217
`define ATX_OPC_WAKE_CTRL_ZERO 10'h21b
`define ATX_OPC_WAKE_CTRL_ONE 10'h214
`define ATX_OPC_WAKE_CTRL_TWO 10'h215
`define ATX_OPC_CLOCK_CTRL 10'h216
`define ATX_OPC_PULLUP_CTRL_ZERO 10'h22d
`define ATX_OPC_PULLUP_CTRL_ONE 10'h22e
// upper six bits of the store group; low four carry the immediate
`define ATX_OPC_STORE_HI 6'h2b

`endif

// file: src/atx_pkg.sv
package atx_pkg;

    typedef enum logic [3:0] {
        op_none,
        op_copy_acc_to_int_ctrl_one,
        op_copy_acc_to_wake_ctrl_zero,
        op_copy_acc_to_wake_ctrl_one,
        op_copy_acc_to_wake_ctrl_two,
        op_store_acc_to_ram_xor_pointer,
        op_copy_acc_to_clock_ctrl,
        op_copy_acc_to_pullup_ctrl_zero,
        op_copy_acc_to_pullup_ctrl_one
    } atx_op_t;

    typedef logic [3:0] atx_nibble_t;

endpackage

// file: src/atx_exec_if.sv
`timescale 1ns/1ns
interface atx_exec_if;
    logic [9:0] opcode;
    atx_pkg::atx_op_t op;
    atx_pkg::atx_nibble_t imm;

    modport decoder (
        input opcode,
        output op,
        output imm
    );

    modport core (
        output opcode,
        input op,
        input imm
    );
endinterface

// file: src/atx_decode.sv
`timescale 1ns/1ns
`include "atx_regs.svh"
module atx_decode (
    atx_exec_if.decoder dec
);

    always_comb begin
        dec.imm = dec.opcode[3:0];
        if (dec.opcode == `ATX_OPC_INT_CTRL_ONE) begin
            dec.op = atx_pkg::op_copy_acc_to_int_ctrl_one;
        end else if (dec.opcode == `ATX_OPC_WAKE_CTRL_ZERO) begin
            dec.op = atx_pkg::op_copy_acc_to_wake_ctrl_zero;
        end else if (dec.opcode == `ATX_OPC_WAKE_CTRL_ONE) begin
            dec.op = atx_pkg::op_copy_acc_to_wake_ctrl_one;
        end else if (dec.opcode == `ATX_OPC_WAKE_CTRL_TWO) begin
            dec.op = atx_pkg::op_copy_acc_to_wake_ctrl_two;
        end else if (dec.opcode[9:4] == `ATX_OPC_STORE_HI) begin
            dec.op = atx_pkg::op_store_acc_to_ram_xor_pointer;
        end else if (dec.opcode == `ATX_OPC_CLOCK_CTRL) begin
            dec.op = atx_pkg::op_copy_acc_to_clock_ctrl;
        end else if (dec.opcode == `ATX_OPC_PULLUP_CTRL_ZERO) begin
            dec.op = atx_pkg::op_copy_acc_to_pullup_ctrl_zero;
        end else if (dec.opcode == `ATX_OPC_PULLUP_CTRL_ONE) begin
            dec.op = atx_pkg::op_copy_acc_to_pullup_ctrl_one;
        end else begin
            dec.op = atx_pkg::op_none;
        end
    end

endmodule // atx_decode

// file: src/atx_top.sv
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "atx_regs.svh"
module atx_top #(
    parameter int DP_W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [3:0] int_ctrl_one,
    output logic [3:0] wake_ctrl_zero,
    output logic [3:0] wake_ctrl_one,
    output logic [3:0] wake_ctrl_two,
    output logic [3:0] clock_ctrl,
    output logic [3:0] pullup_ctrl_zero,
    output logic [3:0] pullup_ctrl_one
);

    localparam int RAM_DEPTH = 1 << DP_W;
    localparam logic [11:0] RAM_END = 12'(`ATX_OFF_RAM_BASE + 4 * RAM_DEPTH);

    atx_exec_if exec_bus ();

    atx_decode u_decode (
        .dec(exec_bus)
    );

    // bus side
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic bus_req;
    logic wr_lo;
    logic wr_instr;

    // architectural state
    logic [3:0] acc_reg;
    logic [3:0] acc_next;
    logic [3:0] file_ptr_reg;
    logic [3:0] file_ptr_next;
    logic [DP_W-1:0] ram_data_pointer_reg;
    logic [DP_W-1:0] ram_data_pointer_next;
    logic carry_flag_reg;
    logic carry_flag_next;
    logic [9:0] opcode_reg;
    logic [9:0] opcode_next;
    logic hit_reg;
    logic hit_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [3:0] int_ctrl_one_reg;
    logic [3:0] int_ctrl_one_next;
    logic [3:0] wake_ctrl_zero_reg;
    logic [3:0] wake_ctrl_zero_next;
    logic [3:0] wake_ctrl_one_reg;
    logic [3:0] wake_ctrl_one_next;
    logic [3:0] wake_ctrl_two_reg;
    logic [3:0] wake_ctrl_two_next;
    logic [3:0] clock_ctrl_reg;
    logic [3:0] clock_ctrl_next;
    logic [3:0] pullup_ctrl_zero_reg;
    logic [3:0] pullup_ctrl_zero_next;
    logic [3:0] pullup_ctrl_one_reg;
    logic [3:0] pullup_ctrl_one_next;
    logic [3:0] ram_reg [RAM_DEPTH];
    logic [3:0] ram_next [RAM_DEPTH];

    function automatic logic in_ram(input logic [11:0] adr);
        in_ram = (adr >= `ATX_OFF_RAM_BASE) && (adr < RAM_END);
    endfunction

    function automatic logic [DP_W-1:0] ram_index(input logic [11:0] adr);
        logic [11:0] rel;
        rel = adr - `ATX_OFF_RAM_BASE;
        ram_index = rel[DP_W+1:2];
    endfunction

    function automatic logic lo_write(input logic wr, input logic [11:0] adr,
        input logic [11:0] target);
        lo_write = wr && (adr == target);
    endfunction

    // one-cycle answer; ack drops the cycle after it was given
    always_comb begin
        bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
        ack_next = bus_req;
        wr_lo = bus_req && wb_we_i && wb_sel_i[0];
        wr_instr = bus_req && wb_we_i && (wb_sel_i[1:0] == 2'b11)
            && (wb_adr_i == `ATX_OFF_INSTR);
        exec_bus.opcode = wb_dat_i[9:0];
    end

    always_comb begin
        // read data holds until the next read
        rdata_next = rdata_reg;
        if (bus_req && !wb_we_i) begin
            rdata_next = 32'h0000_0000;
            if (wb_adr_i == `ATX_OFF_ACC) begin
                rdata_next[3:0] = acc_reg;
            end else if (wb_adr_i == `ATX_OFF_FILE_PTR) begin
                rdata_next[3:0] = file_ptr_reg;
            end else if (wb_adr_i == `ATX_OFF_DATA_PTR) begin
                rdata_next[DP_W-1:0] = ram_data_pointer_reg;
            end else if (wb_adr_i == `ATX_OFF_CARRY) begin
                rdata_next[0] = carry_flag_reg;
            end else if (wb_adr_i == `ATX_OFF_INSTR) begin
                rdata_next[9:0] = opcode_reg;
            end else if (wb_adr_i == `ATX_OFF_STATUS) begin
                rdata_next[`ATX_STATUS_HIT_BIT] = hit_reg;
                // skip never requested by this group
                rdata_next[`ATX_STATUS_SKIP_BIT] = 1'b0;
                rdata_next[`ATX_STATUS_COUNT_LSB +: 8] = count_reg;
            end else if (wb_adr_i == `ATX_OFF_INT_CTRL_ONE) begin
                rdata_next[3:0] = int_ctrl_one_reg;
            end else if (wb_adr_i == `ATX_OFF_WAKE_CTRL_ZERO) begin
                rdata_next[3:0] = wake_ctrl_zero_reg;
            end else if (wb_adr_i == `ATX_OFF_WAKE_CTRL_ONE) begin
                rdata_next[3:0] = wake_ctrl_one_reg;
            end else if (wb_adr_i == `ATX_OFF_WAKE_CTRL_TWO) begin
                rdata_next[3:0] = wake_ctrl_two_reg;
            end else if (wb_adr_i == `ATX_OFF_CLOCK_CTRL) begin
                rdata_next[3:0] = clock_ctrl_reg;
            end else if (wb_adr_i == `ATX_OFF_PULLUP_CTRL_ZERO) begin
                rdata_next[3:0] = pullup_ctrl_zero_reg;
            end else if (wb_adr_i == `ATX_OFF_PULLUP_CTRL_ONE) begin
                rdata_next[3:0] = pullup_ctrl_one_reg;
            end else if (in_ram(wb_adr_i)) begin
                rdata_next[3:0] = ram_reg[ram_index(wb_adr_i)];
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    // software loads of the operand registers
    // no opcode path writes these
    always_comb begin
        acc_next = acc_reg;
        ram_data_pointer_next = ram_data_pointer_reg;
        carry_flag_next = carry_flag_reg;
        if (lo_write(wr_lo, wb_adr_i, `ATX_OFF_ACC)) begin
            acc_next = wb_dat_i[3:0];
        end
        if (lo_write(wr_lo, wb_adr_i, `ATX_OFF_DATA_PTR)) begin
            ram_data_pointer_next = wb_dat_i[DP_W-1:0];
        end
        if (lo_write(wr_lo, wb_adr_i, `ATX_OFF_CARRY)) begin
            carry_flag_next = wb_dat_i[0];
        end
    end

    // instruction status: last opcode, recognised flag, executed count
    always_comb begin
        opcode_next = opcode_reg;
        hit_next = hit_reg;
        count_next = count_reg;
        if (wr_instr) begin
            opcode_next = wb_dat_i[9:0];
            hit_next = (exec_bus.op != atx_pkg::op_none);
            if (exec_bus.op != atx_pkg::op_none) begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < RAM_DEPTH; i++) begin
            ram_next[i] = ram_reg[i];
        end
        if (wr_instr && (exec_bus.op == atx_pkg::op_store_acc_to_ram_xor_pointer)) begin
            ram_next[ram_data_pointer_reg] = acc_reg;
        end
    end

    // instruction execution, one word, one cycle
    always_comb begin
        file_ptr_next = file_ptr_reg;
        int_ctrl_one_next = int_ctrl_one_reg;
        wake_ctrl_zero_next = wake_ctrl_zero_reg;
        wake_ctrl_one_next = wake_ctrl_one_reg;
        wake_ctrl_two_next = wake_ctrl_two_reg;
        clock_ctrl_next = clock_ctrl_reg;
        pullup_ctrl_zero_next = pullup_ctrl_zero_reg;
        pullup_ctrl_one_next = pullup_ctrl_one_reg;
        if (lo_write(wr_lo, wb_adr_i, `ATX_OFF_FILE_PTR)) begin
            file_ptr_next = wb_dat_i[3:0];
        end
        if (wr_instr) begin
            case (exec_bus.op)
                atx_pkg::op_copy_acc_to_int_ctrl_one: begin
                    int_ctrl_one_next = acc_reg;
                end
                atx_pkg::op_copy_acc_to_wake_ctrl_zero: begin
                    wake_ctrl_zero_next = acc_reg;
                end
                atx_pkg::op_copy_acc_to_wake_ctrl_one: begin
                    wake_ctrl_one_next = acc_reg;
                end
                atx_pkg::op_copy_acc_to_wake_ctrl_two: begin
                    wake_ctrl_two_next = acc_reg;
                end
                atx_pkg::op_store_acc_to_ram_xor_pointer: begin
                    file_ptr_next = file_ptr_reg ^ exec_bus.imm;
                end
                atx_pkg::op_copy_acc_to_clock_ctrl: begin
                    clock_ctrl_next = acc_reg;
                end
                atx_pkg::op_copy_acc_to_pullup_ctrl_zero: begin
                    pullup_ctrl_zero_next = acc_reg;
                end
                atx_pkg::op_copy_acc_to_pullup_ctrl_one: begin
                    pullup_ctrl_one_next = acc_reg;
                end
                default: begin
                    file_ptr_next = file_ptr_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            acc_reg <= `ATX_RST_NIBBLE;
            file_ptr_reg <= `ATX_RST_NIBBLE;
            ram_data_pointer_reg <= '0;
            carry_flag_reg <= 1'b0;
            opcode_reg <= `ATX_RST_OPCODE;
            hit_reg <= 1'b0;
            count_reg <= 8'h00;
            int_ctrl_one_reg <= `ATX_RST_NIBBLE;
            wake_ctrl_zero_reg <= `ATX_RST_NIBBLE;
            wake_ctrl_one_reg <= `ATX_RST_NIBBLE;
            wake_ctrl_two_reg <= `ATX_RST_NIBBLE;
            clock_ctrl_reg <= `ATX_RST_NIBBLE;
            pullup_ctrl_zero_reg <= `ATX_RST_NIBBLE;
            pullup_ctrl_one_reg <= `ATX_RST_NIBBLE;
            for (int i = 0; i < RAM_DEPTH; i++) begin
                ram_reg[i] <= `ATX_RST_NIBBLE;
            end
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            acc_reg <= acc_next;
            file_ptr_reg <= file_ptr_next;
            ram_data_pointer_reg <= ram_data_pointer_next;
            carry_flag_reg <= carry_flag_next;
            opcode_reg <= opcode_next;
            hit_reg <= hit_next;
            count_reg <= count_next;
            int_ctrl_one_reg <= int_ctrl_one_next;
            wake_ctrl_zero_reg <= wake_ctrl_zero_next;
            wake_ctrl_one_reg <= wake_ctrl_one_next;
            wake_ctrl_two_reg <= wake_ctrl_two_next;
            clock_ctrl_reg <= clock_ctrl_next;
            pullup_ctrl_zero_reg <= pullup_ctrl_zero_next;
            pullup_ctrl_one_reg <= pullup_ctrl_one_next;
            for (int i = 0; i < RAM_DEPTH; i++) begin
                ram_reg[i] <= ram_next[i];
            end
        end
    end

    // every output comes straight from a register
    always_comb begin
        wb_ack_o = ack_reg;
        wb_dat_o = rdata_reg;
        int_ctrl_one = int_ctrl_one_reg;
        wake_ctrl_zero = wake_ctrl_zero_reg;
        wake_ctrl_one = wake_ctrl_one_reg;
        wake_ctrl_two = wake_ctrl_two_reg;
        clock_ctrl = clock_ctrl_reg;
        pullup_ctrl_zero = pullup_ctrl_zero_reg;
        pullup_ctrl_one = pullup_ctrl_one_reg;
    end

endmodule // atx_top

// file: dv/atx_top_sva.sv
`timescale 1ns/1ns
`include "atx_regs.svh"
module atx_top_sva #(
    parameter int DP_W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] int_ctrl_one,
    input wire logic [3:0] wake_ctrl_zero,
    input wire logic [3:0] wake_ctrl_one,
    input wire logic [3:0] wake_ctrl_two,
    input wire logic [3:0] clock_ctrl,
    input wire logic [3:0] pullup_ctrl_zero,
    input wire logic [3:0] pullup_ctrl_one
);
    logic taken;
    logic [9:0] opc;
    logic [3:0] acc_reg;
    logic [3:0] acc_next;
    logic [27:0] ctrl;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    assign opc = (taken && wb_adr_i == `ATX_OFF_INSTR && wb_sel_i[1:0] == 2'b11) ?
        wb_dat_i[9:0] : 10'h000;
    assign ctrl = {pullup_ctrl_one, pullup_ctrl_zero, clock_ctrl, wake_ctrl_two,
        wake_ctrl_one, wake_ctrl_zero, int_ctrl_one};
    // shadow of the accumulator, written only over the bus
    always_comb begin
        acc_next = acc_reg;
        if (taken && wb_adr_i == `ATX_OFF_ACC && wb_sel_i[0]) begin
            acc_next = wb_dat_i[3:0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 4'h0;
        end else begin
            acc_reg <= acc_next;
        end
    end
    property p_int; opc == `ATX_OPC_INT_CTRL_ONE |=> int_ctrl_one == $past(acc_reg); endproperty
    a_int: assert property (p_int) else $error("int_ctrl_one not loaded");
    property p_wk0; opc == `ATX_OPC_WAKE_CTRL_ZERO |=> wake_ctrl_zero == $past(acc_reg);
    endproperty
    a_wk0: assert property (p_wk0) else $error("wake_ctrl_zero not loaded");
    property p_wk1; opc == `ATX_OPC_WAKE_CTRL_ONE |=> wake_ctrl_one == $past(acc_reg); endproperty
    a_wk1: assert property (p_wk1) else $error("wake_ctrl_one not loaded");
    property p_wk2; opc == `ATX_OPC_WAKE_CTRL_TWO |=> wake_ctrl_two == $past(acc_reg); endproperty
    a_wk2: assert property (p_wk2) else $error("wake_ctrl_two not loaded");
    property p_clk; opc == `ATX_OPC_CLOCK_CTRL |=> clock_ctrl == $past(acc_reg); endproperty
    a_clk: assert property (p_clk) else $error("clock_ctrl not loaded");
    property p_pu0; opc == `ATX_OPC_PULLUP_CTRL_ZERO |=> pullup_ctrl_zero == $past(acc_reg);
    endproperty
    a_pu0: assert property (p_pu0) else $error("pullup_ctrl_zero not loaded");
    property p_pu1; opc == `ATX_OPC_PULLUP_CTRL_ONE |=> pullup_ctrl_one == $past(acc_reg);
    endproperty
    a_pu1: assert property (p_pu1) else $error("pullup_ctrl_one not loaded");
    property p_hold; opc == 10'h000 || opc[9:4] == `ATX_OPC_STORE_HI |=> $stable(ctrl); endproperty
    a_hold: assert property (p_hold) else $error("control output changed");
endmodule // atx_top_sva
bind atx_top atx_top_sva #(.DP_W(DP_W)) u_sva (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_ctrl_one(int_ctrl_one),
    .wake_ctrl_zero(wake_ctrl_zero), .wake_ctrl_one(wake_ctrl_one), .wake_ctrl_two(wake_ctrl_two),
    .clock_ctrl(clock_ctrl), .pullup_ctrl_zero(pullup_ctrl_zero),
    .pullup_ctrl_one(pullup_ctrl_one));

// file: dv/tb_atx_top.sv
`timescale 1ns/1ns
`include "atx_regs.svh"
module tb_atx_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] ic1, wk0, wk1, wk2, ckc, pu0, pu1;
    logic [27:0] ctrl_all;
    logic [27:0] exp_ctrl;
    logic [31:0] rd;
    int errors = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    assign ctrl_all = {pu1, pu0, ckc, wk2, wk1, wk0, ic1};
    atx_top #(.DP_W(6)) u_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_ctrl_one(ic1), .wake_ctrl_zero(wk0),
        .wake_ctrl_one(wk1), .wake_ctrl_two(wk2), .clock_ctrl(ckc), .pullup_ctrl_zero(pu0),
        .pullup_ctrl_one(pu1));
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask
    task automatic xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            $display("[ERR] wb_ack_o expected 1 seen %b", wb_ack_o);
            errors++;
            stop_test();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] adr, input logic [31:0] d);
        xfer(1'b1, adr, 4'hf, d);
    endtask
    task automatic rdc(input string name, input logic [11:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 4'hf, 32'h0);
        check(name, exp, rd);
    endtask
    task automatic t_copy();
        logic [9:0] opc [7] = '{`ATX_OPC_INT_CTRL_ONE, `ATX_OPC_WAKE_CTRL_ZERO,
            `ATX_OPC_WAKE_CTRL_ONE, `ATX_OPC_WAKE_CTRL_TWO, `ATX_OPC_CLOCK_CTRL,
            `ATX_OPC_PULLUP_CTRL_ZERO, `ATX_OPC_PULLUP_CTRL_ONE};
        exp_ctrl = 28'h0;
        check("ctrl after reset", {4'h0, exp_ctrl}, {4'h0, ctrl_all});
        for (int i = 0; i < 7; i++) begin
            wr(`ATX_OFF_ACC, 32'(i + 9));
            wr(`ATX_OFF_INSTR, {22'h0, opc[i]});
            exp_ctrl[i*4 +: 4] = 4'(i + 9);
            check("ctrl outputs", {4'h0, exp_ctrl}, {4'h0, ctrl_all});
            rdc("ctrl readback", `ATX_OFF_INT_CTRL_ONE + 12'(4 * i), {28'h0, exp_ctrl[i*4 +: 4]});
        end
        rdc("acc kept", `ATX_OFF_ACC, 32'hf);
        $display("test copy done");
    endtask
    task automatic t_store();
        wr(`ATX_OFF_CARRY, 32'h1);
        wr(`ATX_OFF_DATA_PTR, 32'h3f);
        wr(`ATX_OFF_FILE_PTR, 32'h5);
        wr(`ATX_OFF_ACC, 32'hc);
        wr(`ATX_OFF_INSTR, 32'h2bf);
        wr(`ATX_OFF_DATA_PTR, 32'h0);
        wr(`ATX_OFF_ACC, 32'h3);
        wr(`ATX_OFF_INSTR, 32'h2b0);
        wr(`ATX_OFF_INSTR, 32'h2b3);
        rdc("ram top nibble", `ATX_OFF_RAM_BASE + 12'h0fc, 32'hc);
        rdc("ram nibble zero", `ATX_OFF_RAM_BASE, 32'h3);
        rdc("file pointer", `ATX_OFF_FILE_PTR, 32'h9);
        rdc("carry", `ATX_OFF_CARRY, 32'h1);
        rdc("acc", `ATX_OFF_ACC, 32'h3);
        rdc("data pointer", `ATX_OFF_DATA_PTR, 32'h0);
        xfer(1'b0, `ATX_OFF_STATUS, 4'hf, 32'h0);
        check("skip flag", 32'h0, {31'h0, rd[1]});
        check("status word", 32'h0000_0a01, rd);
        check("ctrl kept", {4'h0, exp_ctrl}, {4'h0, ctrl_all});
        $display("test store done");
    endtask
    task automatic t_refuse();
        xfer(1'b1, `ATX_OFF_INSTR, 4'h1, 32'h217);
        xfer(1'b1, `ATX_OFF_INSTR, 4'h1, 32'h2b5);
        wr(`ATX_OFF_INSTR, 32'h2ff);
        wr(`ATX_OFF_INT_CTRL_ONE, 32'h0);
        check("ctrl kept", {4'h0, exp_ctrl}, {4'h0, ctrl_all});
        rdc("file pointer kept", `ATX_OFF_FILE_PTR, 32'h9);
        rdc("unmapped", 12'h200, 32'h0);
        rdc("status after unknown", `ATX_OFF_STATUS, 32'h0000_0a00);
        rdc("instr readback", `ATX_OFF_INSTR, 32'h2ff);
        $display("test refuse done");
    endtask
    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check("ctrl after mid reset", 32'h0, {4'h0, ctrl_all});
        rdc("acc after reset", `ATX_OFF_ACC, 32'h0);
        rdc("status after reset", `ATX_OFF_STATUS, 32'h0);
        wr(`ATX_OFF_ACC, 32'h6);
        wr(`ATX_OFF_INSTR, {22'h0, `ATX_OPC_CLOCK_CTRL});
        check("clock ctrl after reset", 32'h6, {28'h0, ckc});
        $display("test reset done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_copy();
        t_store();
        t_refuse();
        t_reset();
        stop_test();
    end
endmodule // tb_atx_top
